// File: include/qac_pkg.sv
/*
 * constants for the quad converter digital configuration register block:
 * register offsets, field positions, write masks, reset value, timing counts.
 * assumes an 8-bit register address space and a 10 MHz block clock.
 */
package qac_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] A_OFFSET_FIX = 8'h3D;
   localparam logic [7:0] A_TEST_HI = 8'h3F;
   localparam logic [7:0] A_TEST_LO = 8'h40;
   localparam logic [7:0] A_BURST_HI = 8'h41;
   localparam logic [7:0] A_DIGITAL = 8'h42;
   localparam logic [7:0] A_BURST_PAIR = 8'h44;
   localparam logic [7:0] A_POWER = 8'h45;
   localparam logic [7:0] A_SKEW_AB = 8'hA9;
   localparam logic [7:0] A_SKEW_CD = 8'hAC;
   localparam logic [7:0] A_QLEVEL = 8'hC3;
   localparam logic [7:0] A_QLEVEL_EN = 8'hC4;
   localparam logic [7:0] A_TUNE0 = 8'hCF;
   localparam logic [7:0] A_TUNE1 = 8'hD4;
   localparam logic [7:0] A_TUNE2 = 8'hD5;
   localparam logic [7:0] A_TUNE3 = 8'hDC;
   localparam logic [7:0] A_TUNE45 = 8'hD7;
   localparam logic [7:0] A_TUNE67 = 8'hDB;
   localparam logic [7:0] A_TUNE8_10 = 8'hF0;
   localparam logic [7:0] A_BOOST_SRC = 8'hEA;
   localparam int NREG = 19;
   // storage index of each decoded register
   localparam int I_OFFSET_FIX = 0;
   localparam int I_TEST_HI = 1;
   localparam int I_TEST_LO = 2;
   localparam int I_BURST_HI = 3;
   localparam int I_DIGITAL = 4;
   localparam int I_BURST_PAIR = 5;
   localparam int I_POWER = 6;
   localparam int I_SKEW_AB = 7;
   localparam int I_SKEW_CD = 8;
   localparam int I_QLEVEL = 9;
   localparam int I_QLEVEL_EN = 10;
   localparam int I_BOOST_SRC = 18;
   localparam logic [7:0] REG_ADDR [NREG] = '{A_OFFSET_FIX, A_TEST_HI, A_TEST_LO,
      A_BURST_HI, A_DIGITAL, A_BURST_PAIR, A_POWER, A_SKEW_AB, A_SKEW_CD, A_QLEVEL,
      A_QLEVEL_EN, A_TUNE0, A_TUNE1, A_TUNE2, A_TUNE3, A_TUNE45, A_TUNE67, A_TUNE8_10,
      A_BOOST_SRC};
   // writable bits; reserved bits are never stored and read as zero
   localparam logic [7:0] REG_MASK [NREG] = '{8'h20, 8'h3F, 8'hFF, 8'h1F, 8'h0F,
      8'hC5, 8'h0D, 8'h78, 8'h78, 8'hFF, 8'h80, 8'h08, 8'h80, 8'h80, 8'h80, 8'h0C,
      8'h30, 8'h38, 8'h80};
   localparam logic [7:0] RESET_VAL = 8'h00;
   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int B_OFFSET_EN = 5;
   localparam int B_AUTO_BURST = 0;
   localparam int B_DIG_EN = 3;
   localparam int B_BAND = 2;
   localparam int B_PAIR_CD = 7;
   localparam int B_PAIR_AB = 6;
   localparam int B_OVR_LSB = 2;
   localparam int B_BOOST_DIS = 0;
   localparam int B_KIND = 3;
   localparam int B_GLOBAL_PD = 2;
   localparam int B_PIN_ROLE = 0;
   localparam int B_LEVEL_EN = 7;
   localparam int B_SRC_SEL = 7;
   ////////////////////////////////////////////////////////////////////////
   // values and timing
   localparam logic [10:0] MID_CODE = 11'h3FF;
   localparam logic [7:0] LEVEL_DEFAULT = 8'hE6;
   localparam logic [21:0] FULL_SCALE = 22'h003FFF;
   localparam logic [21:0] LEVEL_DIV = 22'h0000FF;
   localparam logic [4:0] BURST_BASE = 5'h0D;
   localparam int QUICK_DELAY = 7;
   localparam int CLK_NS = 100;
   localparam int WAKE_FULL_US = 100;
   localparam int WAKE_STBY_US = 10;
   localparam int WAKE_FULL_CYC = (WAKE_FULL_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_STBY_CYC = (WAKE_STBY_US * 1000 + CLK_NS - 1) / CLK_NS;
   // output clock skew per code, in ps
   localparam logic signed [9:0] SKEW_PS [16] = '{0, -30, 70, 30, -150, -180, -70,
      -110, 270, 230, 340, 300, 140, 110, 200, 170};
endpackage

// File: hdl/qac_config_regs.sv
/*
 * digital configuration registers of a quad pipelined converter, with the
 * decoding of each setting into control for the channel logic.
 * assumes a single 10 MHz clock, a plain register port with read data one
 * cycle after the read strobe, and asynchronous shutdown and boost pins.
 */
// The strobed register port was decided locally.
// Function
// - offset fix on all channels when its enable and digital enable set, target 1023
// - 14-bit test word shared by channels: high six bits 3Fh, low 40h
// - burst low-res samples equal two to power 13 plus both counts
// - digital enable bit gates digital gain and offset fix together
// - band select 0 gives 90 MHz boost, 1 gives 45 MHz
// - 44h bit 7 enables burst for pair C/D, bit 6 for A/B
// - in burst, overrange-in-lsb puts channel overrange flag in data bit 0
// - boost disable bit acts only with source override, turning boost off
// - source override 0 lets boost pin rule, 1 the disable bit
// - overrange kind select 0 gives quick flag, 1 normal flag
// - full shutdown bit powers everything down; wake-up takes 100 us
// - shutdown pin means standby (10 us wake) or full shutdown (100 us)
// - four-bit clock-out skew fields at bits 6..3 of A9h and ACh
// - skew codes map to -180..340 ps, code 0 zero, code 4 -150
// - quick threshold is full scale times level field over 255
// - quick overrange flag rises seven clocks after the overload
// - with level enable set after reset the level reads 230
// - all configuration registers reset to 00h
`timescale 1ns/1ns
module qac_config_regs (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic shutdown_pin,
   input wire logic boost_pin,
   input wire logic [3:0][13:0] sample_mag,
   input wire logic [3:0] normal_ovr,
   input wire logic [3:0] adc_lsb,
   output logic offset_fix_on,
   output logic [10:0] offset_target,
   output logic gain_enable,
   output logic [13:0] test_word,
   output logic auto_burst,
   output logic wide_burst_pair_ab,
   output logic wide_burst_pair_cd,
   output logic [4:0] lo_sample_exp,
   output logic [31:0] lo_sample_count,
   output logic boost_on,
   output logic boost_band_45,
   output logic [3:0] overrange_flag,
   output logic [3:0] quick_overrange,
   output logic [3:0] data_lsb,
   output logic [7:0] quick_level,
   output logic [3:0] clk_out_skew_ab,
   output logic [3:0] clk_out_skew_cd,
   output logic signed [9:0] skew_ps_ab,
   output logic signed [9:0] skew_ps_cd,
   output logic full_shutdown,
   output logic standby_all,
   output logic power_ready
);
   typedef enum logic [1:0] {PW_RUN, PW_STBY, PW_OFF, PW_WAKE} qac_pw_t;

   logic [7:0] regs_reg [qac_pkg::NREG];
   logic [7:0] rdata_reg;
   logic level_set_reg;
   logic [2:0] pd_sync_reg;
   logic [2:0] bp_sync_reg;
   logic pin_pd_reg;
   logic pin_boost_reg;
   logic [3:0] over_now;
   logic [3:0][qac_pkg::QUICK_DELAY-1:0] qdly_reg;
   qac_pw_t pw_reg;
   qac_pw_t pw_next;
   logic [9:0] wake_reg;
   logic [9:0] wake_next;
   logic [7:0] level_eff;
   logic [7:0] rd_mux;
   logic full_req;
   logic stby_req;
   logic [3:0] lsb_sel;

   ////////////////////////////////////////////////////////////////////////
   // register storage, one slot per offset, reserved bits masked off
   genvar gi;
   generate
      for (gi = 0; gi < qac_pkg::NREG; gi++) begin : g_reg
         always_ff @(posedge clock) begin
            if (rst) begin
               regs_reg[gi] <= qac_pkg::RESET_VAL;
            end else if (wr && addr == qac_pkg::REG_ADDR[gi]) begin
               regs_reg[gi] <= wdata & qac_pkg::REG_MASK[gi];
            end
         end
      end
   endgenerate

   // remembers whether software has ever written the quick level
   always_ff @(posedge clock) begin
      if (rst) begin
         level_set_reg <= 1'b0;
      end else if (wr && addr == qac_pkg::A_QLEVEL) begin
         level_set_reg <= 1'b1;
      end
   end

   // effective quick level: 230 until software programs its own
   always_comb begin
      level_eff = level_set_reg ? regs_reg[qac_pkg::I_QLEVEL] : qac_pkg::LEVEL_DEFAULT;
   end

   // read multiplexer, unmapped offsets read zero
   always_comb begin
      rd_mux = 8'h00;
      for (int i = 0; i < qac_pkg::NREG; i++) begin
         if (addr == qac_pkg::REG_ADDR[i]) begin
            rd_mux = regs_reg[i];
         end
      end
      if (addr == qac_pkg::A_QLEVEL && regs_reg[qac_pkg::I_QLEVEL_EN][qac_pkg::B_LEVEL_EN]) begin
         rd_mux = level_eff;
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // offset fix, digital gain and test word
   assign gain_enable = regs_reg[qac_pkg::I_DIGITAL][qac_pkg::B_DIG_EN];
   assign offset_fix_on = regs_reg[qac_pkg::I_OFFSET_FIX][qac_pkg::B_OFFSET_EN] &
      gain_enable;
   assign offset_target = qac_pkg::MID_CODE;
   assign test_word = {regs_reg[qac_pkg::I_TEST_HI][5:0], regs_reg[qac_pkg::I_TEST_LO]};

   ////////////////////////////////////////////////////////////////////////
   // burst mode: pair enables and low-resolution sample count
   assign auto_burst = regs_reg[qac_pkg::I_BURST_HI][qac_pkg::B_AUTO_BURST];
   assign wide_burst_pair_cd = regs_reg[qac_pkg::I_BURST_PAIR][qac_pkg::B_PAIR_CD];
   assign wide_burst_pair_ab = regs_reg[qac_pkg::I_BURST_PAIR][qac_pkg::B_PAIR_AB];
   // exponent reaches 31 at most, so the count fits 32 bits
   assign lo_sample_exp = qac_pkg::BURST_BASE + {1'b0, regs_reg[qac_pkg::I_BURST_HI][4:1]} +
      {3'h0, regs_reg[qac_pkg::I_DIGITAL][1:0]};
   assign lo_sample_count = 32'h00000001 << lo_sample_exp;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, a change counts once stages 2 and 3 agree
   always_ff @(posedge clock) begin
      if (rst) begin
         pd_sync_reg <= 3'h0;
         bp_sync_reg <= 3'h0;
      end else begin
         pd_sync_reg <= {pd_sync_reg[1:0], shutdown_pin};
         bp_sync_reg <= {bp_sync_reg[1:0], boost_pin};
      end
   end

   // filtered pin levels
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_pd_reg <= 1'b0;
         pin_boost_reg <= 1'b0;
      end else begin
         if (pd_sync_reg[1] == pd_sync_reg[2]) begin
            pin_pd_reg <= pd_sync_reg[2];
         end
         if (bp_sync_reg[1] == bp_sync_reg[2]) begin
            pin_boost_reg <= bp_sync_reg[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // noise-shaping boost: pin or register source, band select
   assign boost_band_45 = regs_reg[qac_pkg::I_DIGITAL][qac_pkg::B_BAND];
   assign boost_on = regs_reg[qac_pkg::I_BOOST_SRC][qac_pkg::B_SRC_SEL] ?
      ~regs_reg[qac_pkg::I_BURST_PAIR][qac_pkg::B_BOOST_DIS] : pin_boost_reg;

   ////////////////////////////////////////////////////////////////////////
   // quick overrange threshold: level applied only when its enable is set
   assign quick_level = regs_reg[qac_pkg::I_QLEVEL_EN][qac_pkg::B_LEVEL_EN] ?
      level_eff : qac_pkg::LEVEL_DEFAULT;

   // per channel: compare magnitude*255 against full scale*level, then delay
   generate
      for (gi = 0; gi < 4; gi++) begin : g_chan
         assign over_now[gi] = ({8'h00, sample_mag[gi]} * qac_pkg::LEVEL_DIV) >=
            (qac_pkg::FULL_SCALE * {14'h0000, quick_level});
         always_ff @(posedge clock) begin
            if (rst) begin
               qdly_reg[gi] <= '0;
            end else begin
               qdly_reg[gi] <= {qdly_reg[gi][qac_pkg::QUICK_DELAY-2:0], over_now[gi]};
            end
         end
         assign quick_overrange[gi] = qdly_reg[gi][qac_pkg::QUICK_DELAY-1];
      end
   endgenerate

   // flag kind and its placement in the data lsb during burst
   assign overrange_flag = regs_reg[qac_pkg::I_POWER][qac_pkg::B_KIND] ?
      normal_ovr : quick_overrange;
   assign lsb_sel = {{2{wide_burst_pair_cd}}, {2{wide_burst_pair_ab}}} &
      {4{regs_reg[qac_pkg::I_BURST_PAIR][qac_pkg::B_OVR_LSB]}};
   assign data_lsb = (lsb_sel & overrange_flag) | (~lsb_sel & adc_lsb);

   ////////////////////////////////////////////////////////////////////////
   // clock-out skew fields and their picosecond values
   assign clk_out_skew_ab = regs_reg[qac_pkg::I_SKEW_AB][6:3];
   assign clk_out_skew_cd = regs_reg[qac_pkg::I_SKEW_CD][6:3];
   assign skew_ps_ab = qac_pkg::SKEW_PS[clk_out_skew_ab];
   assign skew_ps_cd = qac_pkg::SKEW_PS[clk_out_skew_cd];

   ////////////////////////////////////////////////////////////////////////
   // power state: shutdown by bit or pin, standby by pin, timed wake-up
   assign full_req = regs_reg[qac_pkg::I_POWER][qac_pkg::B_GLOBAL_PD] |
      (pin_pd_reg & regs_reg[qac_pkg::I_POWER][qac_pkg::B_PIN_ROLE]);
   assign stby_req = pin_pd_reg & ~regs_reg[qac_pkg::I_POWER][qac_pkg::B_PIN_ROLE];

   // next state; full shutdown outranks standby
   always_comb begin
      pw_next = pw_reg;
      wake_next = wake_reg;
      case (pw_reg)
         PW_RUN: begin
            if (full_req) begin
               pw_next = PW_OFF;
            end else if (stby_req) begin
               pw_next = PW_STBY;
            end
         end
         PW_OFF: begin
            if (!full_req) begin
               pw_next = PW_WAKE;
               wake_next = 10'(qac_pkg::WAKE_FULL_CYC - 1);
            end
         end
         PW_STBY: begin
            if (full_req) begin
               pw_next = PW_OFF;
            end else if (!stby_req) begin
               pw_next = PW_WAKE;
               wake_next = 10'(qac_pkg::WAKE_STBY_CYC - 1);
            end
         end
         PW_WAKE: begin
            if (full_req) begin
               pw_next = PW_OFF;
            end else if (stby_req) begin
               pw_next = PW_STBY;
            end else if (wake_reg == 10'h000) begin
               pw_next = PW_RUN;
            end else begin
               wake_next = wake_reg - 10'h001;
            end
         end
         default: begin
            pw_next = PW_RUN;
         end
      endcase
   end

   // power state registers
   always_ff @(posedge clock) begin
      if (rst) begin
         pw_reg <= PW_RUN;
         wake_reg <= 10'h000;
      end else begin
         pw_reg <= pw_next;
         wake_reg <= wake_next;
      end
   end
   assign full_shutdown = pw_reg == PW_OFF;
   assign standby_all = pw_reg == PW_STBY;
   assign power_ready = pw_reg == PW_RUN;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_OFFSET_OFF: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_DIGITAL && !wdata[3]) |=> !offset_fix_on)
      else $error("offset fix on without digital enable");
   AST_TEST_HI: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_TEST_HI) |=> test_word[13:8] == $past(wdata[5:0]))
      else $error("test word high bits not from register");
   AST_BURST_EXP: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_DIGITAL) |=>
      lo_sample_exp == 5'(13 + regs_reg[qac_pkg::I_BURST_HI][4:1] + $past(wdata[1:0])))
      else $error("burst sample exponent wrong");
   AST_GAIN_EN: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_DIGITAL) |=> gain_enable == $past(wdata[3]))
      else $error("gain enable not following digital enable");
   AST_BAND: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_DIGITAL) |=> boost_band_45 == $past(wdata[2]))
      else $error("band select wrong");
   AST_PAIR_CD: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_BURST_PAIR) |=> wide_burst_pair_cd == $past(wdata[7]))
      else $error("pair cd burst enable wrong");
   AST_LSB_FLAG: assert property (@(posedge clock) disable iff (rst)
      (wide_burst_pair_ab && regs_reg[qac_pkg::I_BURST_PAIR][qac_pkg::B_OVR_LSB]) |->
      data_lsb[1:0] == overrange_flag[1:0])
      else $error("overrange flag missing from lsb");
   AST_BOOST_DIS: assert property (@(posedge clock) disable iff (rst)
      (regs_reg[qac_pkg::I_BOOST_SRC][7] && regs_reg[qac_pkg::I_BURST_PAIR][0]) |-> !boost_on)
      else $error("boost on while disabled by register");
   AST_KIND: assert property (@(posedge clock) disable iff (rst)
      regs_reg[qac_pkg::I_POWER][3] |-> overrange_flag == normal_ovr)
      else $error("normal overrange not selected");
   AST_SHUTDOWN: assert property (@(posedge clock) disable iff (rst)
      (wr && addr == qac_pkg::A_POWER && wdata[2]) |=> ##1 full_shutdown)
      else $error("full shutdown not entered");
   AST_WAKE: assert property (@(posedge clock) disable iff (rst)
      ($fell(full_shutdown) && pw_reg == PW_WAKE) |-> !power_ready [*8])
      else $error("ready too soon after shutdown");
   AST_QUICK: assert property (@(posedge clock) disable iff (rst)
      over_now[0] |-> ##7 quick_overrange[0])
      else $error("quick overrange not seven cycles after overload");
   AST_RESET: assert property (@(posedge clock) disable iff (rst)
      $past(rst) |-> (test_word == 14'h0000 && !gain_enable && power_ready))
      else $error("configuration not cleared by reset");
   AST_SKEW_CODE4: assert property (@(posedge clock) disable iff (rst)
      clk_out_skew_cd == 4'h4 |-> skew_ps_cd == 10'sh36A)
      else $error("skew code four not -150 ps");
   AST_LEVEL_READ: assert property (@(posedge clock) disable iff (rst)
      (rd && addr == qac_pkg::A_QLEVEL && !level_set_reg &&
      regs_reg[qac_pkg::I_QLEVEL_EN][qac_pkg::B_LEVEL_EN]) |=> rdata == qac_pkg::LEVEL_DEFAULT)
      else $error("quick level does not read 230 after reset");
   COV_LSB: cover property (@(posedge clock) disable iff (rst) lsb_sel[3] && data_lsb[3]);
   COV_WAKE: cover property (@(posedge clock) disable iff (rst)
      pw_reg == PW_WAKE ##1 power_ready);
   COV_QUICK: cover property (@(posedge clock) disable iff (rst) $rose(quick_overrange[2]));
   COV_STBY: cover property (@(posedge clock) disable iff (rst) $rose(standby_all));
endmodule // qac_config_regs

// File: tb/qac_host_model.sv
/*
 host side of the register port: one-cycle write and read cycles.
 assumes the block answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ns
module qac_host_model (
   input wire logic clock,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [7:0] rdata
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // write cycle; released lines show the inverse so stale values never match
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      #1;
   endtask
   // read cycle; data taken at the edge that closes the answer cycle
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      addr <= ~a;
      @(posedge clock);
      d = rdata;
   endtask
endmodule // qac_host_model

// File: tb/qac_config_regs_test.sv
/*
 self-checking bench: register model, decoded settings, quick overrange,
 power states. assumes the host model drives the register port.
*/
`timescale 1ns/1ns
module qac_config_regs_test;
   logic clock, rst, wr, rd, shutdown_pin, boost_pin;
   logic [7:0] addr, wdata, rdata, quick_level;
   logic [3:0][13:0] sample_mag;
   logic [3:0] normal_ovr, adc_lsb, overrange_flag, quick_overrange, data_lsb;
   logic offset_fix_on, gain_enable, auto_burst, wide_burst_pair_ab, wide_burst_pair_cd;
   logic boost_on, boost_band_45, full_shutdown, standby_all, power_ready;
   logic [10:0] offset_target;
   logic [13:0] test_word;
   logic [4:0] lo_sample_exp;
   logic [31:0] lo_sample_count;
   logic [3:0] clk_out_skew_ab, clk_out_skew_cd;
   logic signed [9:0] skew_ps_ab, skew_ps_cd;
   int n_mismatch = 0;
   int samples_checked = 0;
   int mdl[$];
   int ps[16] = '{0, -30, 70, 30, -150, -180, -70, -110, 270, 230, 340, 300, 140, 110, 200, 170};

   qac_config_regs u_qac_config_regs (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .shutdown_pin, .boost_pin, .sample_mag, .normal_ovr, .adc_lsb, .offset_fix_on,
      .offset_target, .gain_enable, .test_word, .auto_burst, .wide_burst_pair_ab,
      .wide_burst_pair_cd, .lo_sample_exp, .lo_sample_count, .boost_on, .boost_band_45,
      .overrange_flag, .quick_overrange, .data_lsb, .quick_level, .clk_out_skew_ab,
      .clk_out_skew_cd, .skew_ps_ab, .skew_ps_cd, .full_shutdown, .standby_all, .power_ready);
   qac_host_model u_qac_host_model (.clock, .addr, .wdata, .wr, .rd, .rdata);

   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      repeat (30000) @(posedge clock);
      n_mismatch++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic hw(input logic [7:0] a, input logic [7:0] d);
      u_qac_host_model.reg_write(a, d);
   endtask
   task automatic hr(input logic [7:0] a, output logic [7:0] d);
      u_qac_host_model.reg_read(a, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // counts cycles until ready and checks the wake span
   task automatic wake(input int lo, input string nm);
      int n;
      n = 0;
      while (power_ready !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk(nm, 32'(n >= lo && n <= lo + 15), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] d;
      int nh;
      int r;
      rst = 1'b1;
      shutdown_pin = 1'b0;
      boost_pin = 1'b0;
      sample_mag = '0;
      normal_ovr = 4'h0;
      adc_lsb = 4'h0;
      r = $urandom(32'hA406C270);
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      // reset values, level default, unmapped place
      for (int i = 0; i < qac_pkg::NREG; i++) begin
         hr(qac_pkg::REG_ADDR[i], d);
         chk("reset value", d, 32'h0);
      end
      hw(qac_pkg::A_QLEVEL_EN, 8'h80);
      hr(qac_pkg::A_QLEVEL, d);
      chk("level default", d, 32'hE6);
      hw(8'h3E, 8'hFF);
      hr(8'h3E, d);
      chk("unmapped", d, 32'h0);
      $display("reset test done");
      // random writes, read back against the queue model, then clear
      for (int i = 0; i < qac_pkg::NREG; i++) begin
         d = 8'($urandom) & qac_pkg::REG_MASK[i];
         hw(qac_pkg::REG_ADDR[i], d);
         mdl.push_back(int'(d));
      end
      for (int i = 0; i < qac_pkg::NREG; i++) begin
         hr(qac_pkg::REG_ADDR[i], d);
         chk("readback", d, 32'(mdl.pop_front()));
         hw(qac_pkg::REG_ADDR[i], 8'h00);
      end
      $display("readback test done");
      // decoded feature settings
      hw(qac_pkg::A_TUNE0, 8'h08);
      for (int k = 0; k < 4; k++) begin
         nh = (k == 3) ? 15 : $urandom_range(14, 0);
         r = $urandom_range(16'h3FFF, 0);
         hw(qac_pkg::A_BURST_PAIR, 8'((3 - k) << 6));
         hw(qac_pkg::A_OFFSET_FIX, 8'((k & 1) << 5));
         hw(qac_pkg::A_BURST_HI, 8'((nh << 1) | (k == 2)));
         hw(qac_pkg::A_DIGITAL, 8'(((k >> 1) << 3) | ((k & 1) << 2) | k));
         hw(qac_pkg::A_TEST_HI, 8'(r >> 8));
         hw(qac_pkg::A_TEST_LO, 8'(r));
         chk("offset fix", offset_fix_on, k == 3);
         chk("offset target", offset_target, 32'h3FF);
         chk("gain", gain_enable, k >> 1);
         chk("band", boost_band_45, k & 1);
         chk("pair ab", wide_burst_pair_ab, (3 - k) & 1);
         chk("pair cd", wide_burst_pair_cd, (3 - k) >> 1);
         chk("test word", test_word, r);
         chk("auto burst", auto_burst, k == 2);
         chk("exponent", lo_sample_exp, 13 + nh + k);
         chk("samples", lo_sample_count, 1 << (13 + nh + k));
      end
      for (int c = 0; c < 16; c++) begin
         hw(qac_pkg::A_SKEW_AB, 8'(c << 3));
         hw(qac_pkg::A_SKEW_CD, 8'((15 - c) << 3));
         chk("skew ab", clk_out_skew_ab, c);
         chk("skew cd", clk_out_skew_cd, 15 - c);
         chk("ps ab", skew_ps_ab, ps[c]);
         chk("ps cd", skew_ps_cd, ps[15 - c]);
      end
      $display("settings test done");
      // boost source: pin first, then the register override
      hw(qac_pkg::A_BURST_PAIR, 8'h01);
      @(posedge clock) boost_pin <= 1'b1;
      tick(8);
      chk("boost pin", boost_on, 32'h1);
      hw(qac_pkg::A_BOOST_SRC, 8'h80);
      chk("boost off", boost_on, 32'h0);
      hw(qac_pkg::A_BURST_PAIR, 8'h00);
      @(posedge clock) boost_pin <= 1'b0;
      tick(8);
      chk("boost reg", boost_on, 32'h1);
      hw(qac_pkg::A_BOOST_SRC, 8'h00);
      chk("boost pin low", boost_on, 32'h0);
      $display("boost test done");
      // quick overrange delay, kind select, lsb replacement
      hw(qac_pkg::A_QLEVEL_EN, 8'h00);
      @(posedge clock) sample_mag <= {4{14'h3FFF}};
      normal_ovr <= 4'hA;
      adc_lsb <= 4'h5;
      for (int e = 1; e <= 7; e++) begin
         tick(1);
         chk("quick delay", quick_overrange, (e == 7) ? 32'hF : 32'h0);
      end
      chk("kind quick", overrange_flag, 32'hF);
      hw(qac_pkg::A_BURST_PAIR, 8'hC4);
      chk("lsb flag", data_lsb, 32'hF);
      hw(qac_pkg::A_POWER, 8'h08);
      chk("kind normal", overrange_flag, 32'hA);
      hw(qac_pkg::A_BURST_PAIR, 8'h44);
      chk("lsb pair ab", data_lsb, 32'h6);
      hw(qac_pkg::A_BURST_PAIR, 8'h00);
      chk("lsb plain", data_lsb, 32'h5);
      // programmed and default thresholds
      hw(qac_pkg::A_POWER, 8'h00);
      hw(qac_pkg::A_QLEVEL_EN, 8'h80);
      hw(qac_pkg::A_QLEVEL, 8'h80);
      chk("level value", quick_level, 32'h80);
      @(posedge clock) sample_mag <= {14'h0000, 14'h3FFF, 14'h1B58, 14'h2328};
      tick(8);
      chk("level 128", quick_overrange, 32'h5);
      hw(qac_pkg::A_QLEVEL_EN, 8'h00);
      chk("level dropped", quick_level, 32'hE6);
      @(posedge clock) sample_mag <= {14'h0000, 14'h0000, 14'h396C, 14'h3A34};
      tick(8);
      chk("level 230", quick_overrange, 32'h1);
      $display("overrange test done");
      // power: register shutdown, pin standby, pin shutdown
      hw(qac_pkg::A_POWER, 8'h04);
      tick(1);
      chk("full down", full_shutdown, 32'h1);
      chk("not ready", power_ready, 32'h0);
      hw(qac_pkg::A_POWER, 8'h00);
      wake(990, "full wake");
      @(posedge clock) shutdown_pin <= 1'b1;
      tick(8);
      chk("standby", standby_all, 32'h1);
      chk("standby full", full_shutdown, 32'h0);
      @(posedge clock) shutdown_pin <= 1'b0;
      wake(95, "standby wake");
      hw(qac_pkg::A_POWER, 8'h01);
      @(posedge clock) shutdown_pin <= 1'b1;
      tick(8);
      chk("pin full", full_shutdown, 32'h1);
      @(posedge clock) shutdown_pin <= 1'b0;
      wake(995, "pin wake");
      $display("power test done");
      // mid-run reset must clear what the earlier tests wrote
      @(posedge clock) rst <= 1'b1;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      hr(qac_pkg::A_POWER, d);
      chk("power after reset", d, 32'h0);
      chk("test word after reset", test_word, 32'h0);
      $display("second reset test done");
      end_of_test();
   end
endmodule // qac_config_regs_test
